/* File: ilactl_pkg.sv */
/*
 * Package for the instruction look-ahead and level 0 pipeline control.
 * Holds widths, register offsets, reset values and state encodings.
 * Assumes a single 50 MHz control clock and APB register access.
 */
package ilactl_pkg;
  localparam int unsigned AW = 16;
  localparam logic [AW-1:0] ADDR_RST = 16'h0000;
  localparam logic [AW-1:0] REGFILE_TOP = 16'h002f;
  localparam logic [AW-1:0] OCT_MASK = 16'hfff8;
  localparam logic [2:0] OCT_LAST = 3'h7;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_HAZ = 8'h08;
  localparam logic [7:0] OFF_BRANCH = 8'h0c;
  localparam logic [7:0] OFF_ALPHA = 8'h10;
  localparam logic [7:0] OFF_PRES = 8'h14;
  localparam logic [7:0] OFF_LOOK = 8'h18;
  localparam logic [7:0] OFF_OUT = 8'h1c;
  localparam logic [7:0] OFF_L1A = 8'h20;

  typedef enum logic [2:0] {
    ILA_L1_BIG = 3'h0,
    ILA_L1_IND2 = 3'h1,
    ILA_L1_HAZ = 3'h2,
    ILA_L1_STF = 3'h3,
    ILA_L1_LDF = 3'h4,
    ILA_L1_OTHER = 3'h5
  } ila_l1_state_t;

  typedef enum logic [1:0] {
    ILA_SRC_BUF = 2'h0,
    ILA_SRC_RF = 2'h1,
    ILA_SRC_MIF = 2'h2
  } ila_src_t;

  typedef enum logic [1:0] {
    ILA_L0_RUN = 2'h0,
    ILA_L0_WAITMEM = 2'h1
  } ila_l0_state_t;

  // pipe-negating events from level 3
  typedef struct packed {
    logic hazard;
    logic target_fail;
    logic file_op;
    logic negate_pipe;
    logic negate_l1;
  } ila_l3_evt_t;

  // memory request toward the requester
  typedef struct packed {
    logic req;
    logic [AW-1:0] addr;
  } ila_mreq_t;

  // object / word select toward the instruction files
  typedef struct packed {
    logic load;
    ila_src_t src;
    logic buf_b;
    logic [AW-1:0] addr;
  } ila_sel_t;
endpackage

/* File: ilactl_top.sv */
/*
 * Look-ahead recovery and level 0 control for the instruction unit head.
 * Assumes pclk at 50 MHz, level 3 events and level 1 controller state
 * synchronous to pclk, and an APB master that holds requests until pready.
 */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - on level 3 hazard copy hazard address into output, present, look-ahead
// - hazard recovery clears look-ahead-ordered and all three branch flags
// - memory request for hazarded octet issues on the following cycle
// - branch not taken or skipped at level 3 means target fail
// - target fail in present octet: branch addr to present, look-ahead if unordered
// - target fail outside present octet sets deferred-fetch for next clock fetch
// - both target-fail cases clear all branch status flags
// - file-op negate with octet end: look-ahead to present, toggle pointer
// - load instruction register only while level 1 inactive
// - at least one idle clock between instruction register loads
// - indirect/execute, level 1 active, no M/T hazard: clear level 1 activity
// - object from register file when alpha <= 2F, not branch, no inhibit
// - alpha in present octet uses pointer buffer, look-ahead uses other
// - local object sets activity now; else wait for memory file deposit
// - no indirect/execute: buffer A if pointer zero, else buffer B
// - no load while level 1 in indirect-2, hazard, store or load file
// - selected buffer full raises accept request; answered by load ack
// - ack in idle state with level 3 negating: leave activity clear
// - otherwise set activity and copy present address to level 1 address
// - level 1 active: clear when indirect-2, or hazard with negation
// - level 1 active, hazard without negation or other state: do nothing
// - level 3 pipe negate clears level 1 activity on next clock
module ilactl_top #(
  parameter int unsigned ADDR_W = ilactl_pkg::AW
) (
  input wire logic pclk, // control clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire ilactl_pkg::ila_l3_evt_t l3_evt, // level 3 events
  input wire logic l3_ind_exec, // indirect or execute at level 3
  input wire logic l3_is_branch, // level 3 is a branch
  input wire logic l3_brn_fail, // branch not taken at level 3
  input wire logic l3_skipped, // branch skipped
  input wire logic l1_mt_hazard, // M or T hazard at level 1
  input wire ilactl_pkg::ila_l1_state_t l1_state, // level 1 ctrl state
  input wire logic buf_a_full, // buffer a holds valid octet
  input wire logic buf_b_full, // buffer b holds valid octet
  input wire logic ir_load_ack, // load acknowledge from look-ahead
  input wire logic mif_ready, // octet deposited in memory file
  input wire logic mem_rd_ack, // requester can take a read
  output ilactl_pkg::ila_mreq_t mem_req, // request to memory requester
  output ilactl_pkg::ila_sel_t word_sel, // word select to files
  output logic ir_accept_request, // instruction register can accept
  output logic level1_active, // level 1 activity bit
  output logic [ADDR_W-1:0] level1_addr_reg // level 1 address
);
  logic [ADDR_W-1:0] hazard_addr_ff, branch_addr_ff, alpha_ff;
  logic [ADDR_W-1:0] present_ff, lookahead_ff, output_ff;
  logic lookahead_ordered_flag_ff, branch_in_pipe_flag_ff;
  logic target_in_unit_flag_ff, branch_full_flag_ff;
  logic deferred_fetch_flag_ff, buffer_out_pointer_ff;
  logic reg_inhibit_ff, ctrl_enable_ff, hazard_pend_ff;
  logic l1_act_ff, l1_busy_ff, loaded_ff, target_fail, pres_match;
  logic alpha_pres, alpha_look, alpha_rf, ie_path, l1_blocked;
  logic sel_full, clr_l1, set_l1;
  ilactl_pkg::ila_l0_state_t l0_state_ff, nxt_l0_state;
  ilactl_pkg::ila_sel_t nxt_sel;

  assign target_fail = l3_brn_fail | l3_skipped;
  assign pres_match = (branch_addr_ff & ilactl_pkg::OCT_MASK) ==
                      (present_ff & ilactl_pkg::OCT_MASK);

  // apb slave: zero wait states, unmapped reads zero with error
  logic acc;
  assign acc = psel & penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          ilactl_pkg::OFF_CTRL:
            prdata <= {30'h0, reg_inhibit_ff, ctrl_enable_ff};
          ilactl_pkg::OFF_STAT:
            prdata <= {24'h0, buffer_out_pointer_ff, l1_act_ff,
                       deferred_fetch_flag_ff, branch_full_flag_ff,
                       target_in_unit_flag_ff, branch_in_pipe_flag_ff,
                       lookahead_ordered_flag_ff, hazard_pend_ff};
          ilactl_pkg::OFF_HAZ: prdata <= 32'(hazard_addr_ff);
          ilactl_pkg::OFF_BRANCH: prdata <= 32'(branch_addr_ff);
          ilactl_pkg::OFF_ALPHA: prdata <= 32'(alpha_ff);
          ilactl_pkg::OFF_PRES: prdata <= 32'(present_ff);
          ilactl_pkg::OFF_LOOK: prdata <= 32'(lookahead_ff);
          ilactl_pkg::OFF_OUT: prdata <= 32'(output_ff);
          ilactl_pkg::OFF_L1A: prdata <= 32'(level1_addr_reg);
          default: pslverr <= 1'b1;
        endcase
      end else if (psel & ~penable) begin
        case (paddr)
          ilactl_pkg::OFF_CTRL, ilactl_pkg::OFF_HAZ,
          ilactl_pkg::OFF_BRANCH, ilactl_pkg::OFF_ALPHA: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // software loaded address sources and controls
  logic wr_ok;
  assign wr_ok = acc & pwrite & pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_enable_ff <= 1'b0;
      reg_inhibit_ff <= 1'b0;
      hazard_addr_ff <= ilactl_pkg::ADDR_RST;
      branch_addr_ff <= ilactl_pkg::ADDR_RST;
      alpha_ff <= ilactl_pkg::ADDR_RST;
    end else if (wr_ok) begin
      case (paddr)
        ilactl_pkg::OFF_CTRL: begin
          ctrl_enable_ff <= pwdata[0];
          reg_inhibit_ff <= pwdata[1];
        end
        ilactl_pkg::OFF_HAZ: hazard_addr_ff <= pwdata[ADDR_W-1:0];
        ilactl_pkg::OFF_BRANCH: branch_addr_ff <= pwdata[ADDR_W-1:0];
        ilactl_pkg::OFF_ALPHA: alpha_ff <= pwdata[ADDR_W-1:0];
        default: ctrl_enable_ff <= ctrl_enable_ff;
      endcase
    end
  end

  // look-ahead recovery: address registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      present_ff <= ilactl_pkg::ADDR_RST;
      lookahead_ff <= ilactl_pkg::ADDR_RST;
      output_ff <= ilactl_pkg::ADDR_RST;
      buffer_out_pointer_ff <= 1'b0;
    end else if (l3_evt.hazard) begin
      output_ff <= hazard_addr_ff;
      present_ff <= hazard_addr_ff;
      lookahead_ff <= hazard_addr_ff;
    end else if (target_fail) begin
      if (pres_match) begin
        present_ff <= branch_addr_ff;
        if (!lookahead_ordered_flag_ff)
          lookahead_ff <= branch_addr_ff;
      end else if (mem_rd_ack) begin
        output_ff <= branch_addr_ff;
      end
    end else if (l3_evt.file_op) begin
      if (present_ff[2:0] == ilactl_pkg::OCT_LAST) begin
        present_ff <= lookahead_ff;
        buffer_out_pointer_ff <= ~buffer_out_pointer_ff;
      end
    end
  end

  // look-ahead recovery: flags; hazard wins over target fail
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lookahead_ordered_flag_ff <= 1'b0;
      branch_in_pipe_flag_ff <= 1'b0;
      target_in_unit_flag_ff <= 1'b0;
      branch_full_flag_ff <= 1'b0;
      deferred_fetch_flag_ff <= 1'b0;
      hazard_pend_ff <= 1'b0;
    end else begin
      hazard_pend_ff <= l3_evt.hazard;
      deferred_fetch_flag_ff <= 1'b0;
      if (l3_evt.hazard) begin
        lookahead_ordered_flag_ff <= 1'b0;
        branch_in_pipe_flag_ff <= 1'b0;
        target_in_unit_flag_ff <= 1'b0;
        branch_full_flag_ff <= 1'b0;
      end else if (target_fail) begin
        branch_in_pipe_flag_ff <= 1'b0;
        target_in_unit_flag_ff <= 1'b0;
        branch_full_flag_ff <= 1'b0;
        if (!pres_match)
          deferred_fetch_flag_ff <= 1'b1;
      end else if (hazard_pend_ff | deferred_fetch_flag_ff) begin
        lookahead_ordered_flag_ff <= 1'b0;
      end else if (wr_ok && paddr == ilactl_pkg::OFF_CTRL) begin
        // software may preset the flags; recovery above takes priority
        lookahead_ordered_flag_ff <= lookahead_ordered_flag_ff | pwdata[2];
        branch_in_pipe_flag_ff <= branch_in_pipe_flag_ff | pwdata[3];
        target_in_unit_flag_ff <= target_in_unit_flag_ff | pwdata[4];
        branch_full_flag_ff <= branch_full_flag_ff | pwdata[5];
      end
    end
  end

  // memory request one cycle after the setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req <= '0;
    end else begin
      mem_req.req <= 1'b0;
      if (hazard_pend_ff) begin
        mem_req.req <= 1'b1;
        mem_req.addr <= output_ff;
      end else if (deferred_fetch_flag_ff) begin
        mem_req.req <= 1'b1;
        mem_req.addr <= branch_addr_ff;
      end
    end
  end

  // level 0 word selection
  assign alpha_rf = (alpha_ff <= ilactl_pkg::REGFILE_TOP) & ~l3_is_branch &
                    ~reg_inhibit_ff;
  assign alpha_pres = (alpha_ff & ilactl_pkg::OCT_MASK) ==
                      (present_ff & ilactl_pkg::OCT_MASK);
  assign alpha_look = (alpha_ff & ilactl_pkg::OCT_MASK) ==
                      (lookahead_ff & ilactl_pkg::OCT_MASK);
  assign ie_path = ctrl_enable_ff & l3_ind_exec;
  assign l1_blocked = (l1_state == ilactl_pkg::ILA_L1_IND2) |
                      (l1_state == ilactl_pkg::ILA_L1_HAZ) |
                      (l1_state == ilactl_pkg::ILA_L1_STF) |
                      (l1_state == ilactl_pkg::ILA_L1_LDF);
  assign sel_full = buffer_out_pointer_ff ? buf_b_full : buf_a_full;

  always_comb begin
    nxt_sel = '0;
    nxt_l0_state = l0_state_ff;
    set_l1 = 1'b0;
    clr_l1 = 1'b0;
    nxt_sel.buf_b = buffer_out_pointer_ff;
    nxt_sel.addr = present_ff;
    if (l3_evt.negate_pipe) begin
      clr_l1 = 1'b1;
      nxt_l0_state = ilactl_pkg::ILA_L0_RUN;
    end else if (!ctrl_enable_ff) begin
      nxt_l0_state = ilactl_pkg::ILA_L0_RUN;
    end else if (l0_state_ff == ilactl_pkg::ILA_L0_WAITMEM) begin
      nxt_sel.src = ilactl_pkg::ILA_SRC_MIF;
      nxt_sel.addr = alpha_ff;
      if (mif_ready) begin
        set_l1 = 1'b1;
        nxt_sel.load = 1'b1;
        nxt_l0_state = ilactl_pkg::ILA_L0_RUN;
      end
    end else if (ie_path) begin
      nxt_sel.addr = alpha_ff;
      if (l1_act_ff) begin
        if (!l1_mt_hazard)
          clr_l1 = 1'b1;
      end else if (!loaded_ff) begin
        nxt_sel.load = 1'b1;
        if (alpha_rf) begin
          nxt_sel.src = ilactl_pkg::ILA_SRC_RF;
          set_l1 = 1'b1;
        end else if (alpha_pres | alpha_look) begin
          nxt_sel.buf_b = alpha_pres ? buffer_out_pointer_ff :
                          ~buffer_out_pointer_ff;
          set_l1 = 1'b1;
        end else begin
          nxt_sel.load = 1'b0;
          nxt_sel.src = ilactl_pkg::ILA_SRC_MIF;
          nxt_l0_state = ilactl_pkg::ILA_L0_WAITMEM;
        end
      end
    end else if (!l1_act_ff) begin
      if (!l1_blocked && !loaded_ff && ir_load_ack) begin
        nxt_sel.load = 1'b1;
        if (!(l1_state == ilactl_pkg::ILA_L1_BIG && l3_evt.negate_l1))
          set_l1 = 1'b1;
      end
    end else begin
      if (l1_state == ilactl_pkg::ILA_L1_IND2 ||
          (l1_state == ilactl_pkg::ILA_L1_HAZ && l3_evt.negate_l1))
        clr_l1 = 1'b1;
      // hazard without negation or other states: wait
    end
  end

  // level 0 state, activity bit and load bubble
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      l0_state_ff <= ilactl_pkg::ILA_L0_RUN;
      l1_act_ff <= 1'b0;
      loaded_ff <= 1'b0;
      level1_addr_reg <= '0;
      word_sel <= '0;
      ir_accept_request <= 1'b0;
    end else begin
      l0_state_ff <= nxt_l0_state;
      word_sel <= nxt_sel;
      loaded_ff <= nxt_sel.load;
      if (clr_l1)
        l1_act_ff <= 1'b0;
      else if (set_l1)
        l1_act_ff <= 1'b1;
      if (set_l1 && !ie_path)
        level1_addr_reg <= present_ff;
      else if (set_l1)
        level1_addr_reg <= alpha_ff;
      ir_accept_request <= ctrl_enable_ff & ~ie_path & ~l1_act_ff &
                           ~l1_blocked & sel_full &
                           ~l3_evt.negate_pipe;
    end
  end
  assign level1_active = l1_act_ff;

  property p_hazard_copy;
    @(posedge pclk) disable iff (!presetn)
    l3_evt.hazard |=> present_ff == $past(hazard_addr_ff) &&
      output_ff == $past(hazard_addr_ff);
  endproperty
  a_hazard_copy: assert property (p_hazard_copy)
    else $error("hazard address not copied");
  property p_haz_flags;
    @(posedge pclk) disable iff (!presetn)
    l3_evt.hazard |=> !lookahead_ordered_flag_ff && !branch_full_flag_ff;
  endproperty
  a_haz_flags: assert property (p_haz_flags)
    else $error("hazard flags not cleared");
  property p_haz_req;
    @(posedge pclk) disable iff (!presetn)
    l3_evt.hazard |=> ##1 mem_req.req;
  endproperty
  a_haz_req: assert property (p_haz_req)
    else $error("hazard fetch missing");
  property p_tf_defer;
    @(posedge pclk) disable iff (!presetn)
    (target_fail && !l3_evt.hazard && !pres_match) |=>
      deferred_fetch_flag_ff ##1 mem_req.req;
  endproperty
  a_tf_defer: assert property (p_tf_defer)
    else $error("deferred fetch missing");
  property p_tf_flags;
    @(posedge pclk) disable iff (!presetn)
    target_fail |=> !branch_in_pipe_flag_ff && !target_in_unit_flag_ff;
  endproperty
  a_tf_flags: assert property (p_tf_flags)
    else $error("branch flags not cleared");
  property p_bubble;
    @(posedge pclk) disable iff (!presetn)
    word_sel.load |=> !word_sel.load;
  endproperty
  a_bubble: assert property (p_bubble)
    else $error("back to back loads");
  property p_negate;
    @(posedge pclk) disable iff (!presetn)
    l3_evt.negate_pipe |=> !level1_active;
  endproperty
  a_negate: assert property (p_negate)
    else $error("negate did not clear level 1");
  property p_wait_hold;
    @(posedge pclk) disable iff (!presetn)
    (l0_state_ff == ilactl_pkg::ILA_L0_WAITMEM && !mif_ready &&
     !l3_evt.negate_pipe && ctrl_enable_ff) |=> $stable(l1_act_ff);
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("activity changed while waiting");
  property p_l1_load;
    @(posedge pclk) disable iff (!presetn)
    word_sel.load |-> !$past(l1_act_ff);
  endproperty
  a_l1_load: assert property (p_l1_load)
    else $error("load while level 1 active");
  c_haz: cover property (@(posedge pclk) l3_evt.hazard ##2 mem_req.req);
  c_load: cover property (@(posedge pclk) word_sel.load ##1 level1_active);
  c_wait: cover property (@(posedge pclk)
    l0_state_ff == ilactl_pkg::ILA_L0_WAITMEM ##1 mif_ready);
endmodule
`default_nettype wire

/* File: ilactl_partner.sv */
/*
 * Far-side model: memory requester and look-ahead load answer.
 * Assumes the design's mem_req and ir_accept_request are pclk-registered.
 */
`timescale 1ns/100ps
`default_nettype none
module ilactl_partner #(
  parameter int LAT = 3
) (
  input wire logic pclk, // control clock
  input wire logic presetn, // async reset, active low
  input wire ilactl_pkg::ila_mreq_t mem_req, // fetch request
  input wire logic ir_accept_request, // ir can take a word
  output logic mem_rd_ack, // requester free for a read
  output logic mif_ready, // octet sits in memory file
  output logic ir_load_ack // load ir answer
);
  logic [3:0] cnt_ff;
  // busy while a fetch is in flight, so a slow memory is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 4'h0;
      mif_ready <= 1'b0;
      mem_rd_ack <= 1'b1;
    end else if (mem_req.req) begin
      cnt_ff <= 4'(LAT);
      mif_ready <= 1'b0;
      mem_rd_ack <= 1'b0;
    end else if (cnt_ff == 4'h1) begin
      cnt_ff <= 4'h0;
      mif_ready <= 1'b1;
      mem_rd_ack <= 1'b1;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_load_ack <= 1'b0;
    end else begin
      ir_load_ack <= ir_accept_request & ~ir_load_ack;
    end
  end
endmodule
`default_nettype wire

/* File: tb_instr_lookahead_level0_ctrl.sv */
/*
 * Self-checking bench for the look-ahead recovery and level 0 control.
 * Assumes zero-wait APB answers and registered one-cycle output pulses.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_instr_lookahead_level0_ctrl;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ilactl_pkg::ila_l3_evt_t l3_evt = '0;
  logic l3_ind_exec = 1'b0;
  logic l3_is_branch = 1'b0;
  logic l3_brn_fail = 1'b0;
  logic l3_skipped = 1'b0;
  logic l1_mt_hazard = 1'b0;
  ilactl_pkg::ila_l1_state_t l1_state = ilactl_pkg::ILA_L1_BIG;
  logic buf_a_full = 1'b0;
  logic buf_b_full = 1'b0;
  logic ir_load_ack;
  logic mif_ready;
  logic mem_rd_ack;
  ilactl_pkg::ila_mreq_t mem_req;
  ilactl_pkg::ila_sel_t word_sel;
  ilactl_pkg::ila_sel_t last_sel = '0;
  logic ir_accept_request;
  logic level1_active;
  logic [15:0] level1_addr_reg;
  logic [15:0] req_addr = 16'h0;
  logic [31:0] rdat;
  logic [31:0] p_val;
  logic rerr;
  logic ld_prev = 1'b0;
  int n_errors = 0;
  int checked = 0;
  int n_loads = 0;
  int n_req = 0;
  int base;

  always #10 pclk = ~pclk;

  ilactl_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .l3_evt(l3_evt),
    .l3_ind_exec(l3_ind_exec), .l3_is_branch(l3_is_branch),
    .l3_brn_fail(l3_brn_fail), .l3_skipped(l3_skipped),
    .l1_mt_hazard(l1_mt_hazard), .l1_state(l1_state),
    .buf_a_full(buf_a_full), .buf_b_full(buf_b_full),
    .ir_load_ack(ir_load_ack), .mif_ready(mif_ready),
    .mem_rd_ack(mem_rd_ack), .mem_req(mem_req), .word_sel(word_sel),
    .ir_accept_request(ir_accept_request), .level1_active(level1_active),
    .level1_addr_reg(level1_addr_reg));

  ilactl_partner #(.LAT(3)) u_far (.pclk(pclk), .presetn(presetn),
    .mem_req(mem_req), .ir_accept_request(ir_accept_request),
    .mem_rd_ack(mem_rd_ack), .mif_ready(mif_ready),
    .ir_load_ack(ir_load_ack));

  task automatic stop_test();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // apb master; enters and leaves just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_errors++;
      stop_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] msk, exp);
    apb(1'b0, a, 32'h0);
    chk(rdat & msk, exp, "register read");
  endtask

  // bits: hazard,tf,file,negate_pipe,negate_l1,brn_fail,skipped
  task automatic pulse(input logic [6:0] v);
    {l3_evt, l3_brn_fail, l3_skipped} <= v;
    @(posedge pclk);
    {l3_evt, l3_brn_fail, l3_skipped} <= 7'h00;
    @(posedge pclk);
  endtask

  task automatic wait_act(input logic v);
    int n;
    for (n = 0; n < 30 && level1_active !== v; n++) @(posedge pclk);
    chk({31'h0, level1_active}, {31'h0, v}, "activity bit");
  endtask

  task automatic wait_req(input logic [15:0] exp);
    int n;
    for (n = 0; n < 10 && n_req == base; n++) @(posedge pclk);
    chk({n_req != base, 15'h0, req_addr & ilactl_pkg::OCT_MASK},
        {1'b1, 15'h0, exp & ilactl_pkg::OCT_MASK}, "fetch request");
  endtask

  // sampled mid-cycle so the initial block never races this monitor
  always @(negedge pclk) begin
    if (word_sel.load === 1'b1) begin
      chk({31'h0, ld_prev}, 32'h0, "loads back to back");
      n_loads++;
      last_sel = word_sel;
    end
    ld_prev = (word_sel.load === 1'b1);
    if (mem_req.req === 1'b1) begin
      n_req++;
      req_addr = mem_req.addr;
    end
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({mem_req.req, word_sel.load, ir_accept_request, level1_active},
        4'h0, "outputs after reset");
    rd_chk(ilactl_pkg::OFF_STAT, 32'hff, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({rerr, rdat[30:0]}, 32'h80000000, "unmapped read");
    apb(1'b1, ilactl_pkg::OFF_HAZ, 32'h0123);
    apb(1'b1, ilactl_pkg::OFF_CTRL, 32'h3c);
    rd_chk(ilactl_pkg::OFF_STAT, 32'h1e, 32'h1e);
    base = n_req;
    pulse(7'h40);
    wait_req(16'h0123);
    rd_chk(ilactl_pkg::OFF_OUT, 32'hffff, 32'h0123);
    rd_chk(ilactl_pkg::OFF_PRES, 32'hffff, 32'h0123);
    rd_chk(ilactl_pkg::OFF_LOOK, 32'hffff, 32'h0123);
    rd_chk(ilactl_pkg::OFF_STAT, 32'h1e, 32'h0);
    // branch target at word 7 so the file op sees the octet end
    apb(1'b1, ilactl_pkg::OFF_BRANCH, 32'h0127);
    apb(1'b1, ilactl_pkg::OFF_CTRL, 32'h3c);
    pulse(7'h02);
    rd_chk(ilactl_pkg::OFF_PRES, 32'hffff, 32'h0127);
    rd_chk(ilactl_pkg::OFF_STAT, 32'h1e, 32'h02);
    // look-ahead already ordered, so it keeps the hazard address
    rd_chk(ilactl_pkg::OFF_LOOK, 32'hffff, 32'h0123);
    p_val = 32'h0123;
    pulse(7'h10);
    rd_chk(ilactl_pkg::OFF_PRES, 32'hffff, p_val);
    rd_chk(ilactl_pkg::OFF_STAT, 32'h80, 32'h80);
    buf_b_full <= 1'b1;
    apb(1'b1, ilactl_pkg::OFF_CTRL, 32'h1);
    wait_act(1'b1);
    chk({last_sel.src, last_sel.buf_b}, 3'h1, "buffer b word");
    chk(level1_addr_reg, p_val, "level 1 address");
    base = n_loads;
    repeat (8) @(posedge pclk);
    chk(n_loads, base, "load while active");
    l1_state <= ilactl_pkg::ILA_L1_IND2;
    wait_act(1'b0);
    l1_state <= ilactl_pkg::ILA_L1_HAZ;
    base = n_loads;
    repeat (8) @(posedge pclk);
    chk(n_loads, base, "load in hazard state");
    l1_state <= ilactl_pkg::ILA_L1_BIG;
    wait_act(1'b1);
    pulse(7'h08);
    chk({31'h0, level1_active}, 32'h0, "negate clears");
    // indirect objects: register file, present octet, memory file
    apb(1'b1, ilactl_pkg::OFF_ALPHA, 32'h0020);
    l3_ind_exec <= 1'b1;
    repeat (12) @(posedge pclk);
    chk(last_sel.src, ilactl_pkg::ILA_SRC_RF, "rf object");
    wait_act(1'b1);
    wait_act(1'b0);
    apb(1'b1, ilactl_pkg::OFF_ALPHA, p_val);
    repeat (12) @(posedge pclk);
    chk({last_sel.src, last_sel.buf_b}, 3'h1, "local object");
    apb(1'b1, ilactl_pkg::OFF_ALPHA, 32'h0600);
    repeat (20) @(posedge pclk);
    chk(last_sel.src, ilactl_pkg::ILA_SRC_MIF, "far object");
    l3_ind_exec <= 1'b0;
    apb(1'b1, ilactl_pkg::OFF_CTRL, 32'h38);
    apb(1'b1, ilactl_pkg::OFF_BRANCH, 32'h0450);
    base = n_req;
    pulse(7'h01);
    wait_req(16'h0450);
    rd_chk(ilactl_pkg::OFF_STAT, 32'h1c, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
